// >>> verilog/rl_params.svh
// Constants for the remote/local state machine
`ifndef RL_PARAMS_SVH
`define RL_PARAMS_SVH
`define RL_ST_LOCS 4'h1
`define RL_ST_REMS 4'h2
`define RL_ST_LWLS 4'h4
`define RL_ST_RWLS 4'h8
`define RL_ADDR_CTRL 4'h0
`define RL_ADDR_STATE 4'h4
`define RL_ADDR_IRQ_STAT 4'h8
`define RL_ADDR_IRQ_MASK 4'hC
`define RL_CTRL_RESET 8'h00
`define RL_MASK_RESET 8'h00
`define RL_BIT_REMOTE 0
`define RL_BIT_LOCKOUT 1
`define RL_BIT_WRITE_REMOTE 2
`define RL_BIT_WRITE_LOCKOUT 3
`define RL_EV_URQ 0
`define RL_EV_CHANGE 1
`endif

// >>> verilog/rl_pkg.sv
// Types for the remote/local state machine
`include "rl_params.svh"
package rl_pkg;
  typedef enum logic [3:0] {
    ST_LOCAL = `RL_ST_LOCS,
    ST_REMOTE = `RL_ST_REMS,
    ST_LOCAL_LOCK = `RL_ST_LWLS,
    ST_REMOTE_LOCK = `RL_ST_RWLS
  } rl_state_t;
  typedef struct packed {
    logic rem;
    logic mla;
    logic gtl;
    logic llo;
  } bus_msg_t;
endpackage : rl_pkg

// >>> verilog/remote_local_state_machine.sv
// Remote/local control state machine with key gating and user request
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "rl_params.svh"
module remote_local_state_machine
  import rl_pkg::*;
#(
  parameter int KEY_W = 16,
  parameter int ENTER_BIT = 0,
  parameter int POWER_BIT = 1,
  parameter bit NO_LOCKOUT_CAP = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bus_msg_t msg_i,
  input wire logic [KEY_W-1:0] keys_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic [KEY_W-1:0] keys_o,
  output logic [3:0] state_o,
  output logic urq_o,
  output logic irq_o
);
  initial begin
    if (KEY_W < 2 || ENTER_BIT >= KEY_W || POWER_BIT >= KEY_W ||
        ENTER_BIT == POWER_BIT) begin
      $error("remote_local_state_machine: bad key parameters");
    end
  end

  // Two flip-flop synchronisers for pins from outside the clock domain
  bus_msg_t msg_s1;
  bus_msg_t msg;
  logic [KEY_W-1:0] keys_s1;
  logic [KEY_W-1:0] keys;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msg_s1 <= '0;
      msg <= '0;
      keys_s1 <= '0;
      keys <= '0;
    end else begin
      msg_s1 <= msg_i;
      msg <= msg_s1;
      keys_s1 <= keys_i;
      keys <= keys_s1;
    end
  end

  // Enter edge detect on the synchronised key
  logic enter_q;
  logic enter_press;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enter_q <= 1'b0;
    end else begin
      enter_q <= keys[ENTER_BIT];
    end
  end
  assign enter_press = keys[ENTER_BIT] & ~enter_q;

  // Software property writes are one-cycle requests
  logic sw_rem_wr;
  logic sw_lock_wr;
  logic sw_rem_val;
  logic sw_lock_val;
  logic [7:0] ctrl;
  assign sw_rem_wr = wr_i && addr_i == `RL_ADDR_CTRL &&
                     wdata_i[`RL_BIT_WRITE_REMOTE];
  assign sw_lock_wr = wr_i && addr_i == `RL_ADDR_CTRL &&
                      wdata_i[`RL_BIT_WRITE_LOCKOUT];
  assign sw_rem_val = wdata_i[`RL_BIT_REMOTE];
  assign sw_lock_val = wdata_i[`RL_BIT_LOCKOUT];

  // Last values written to the properties, read back by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `RL_CTRL_RESET;
    end else begin
      if (sw_rem_wr) begin
        ctrl[`RL_BIT_REMOTE] <= sw_rem_val;
      end
      if (sw_lock_wr) begin
        ctrl[`RL_BIT_LOCKOUT] <= sw_lock_val;
      end
    end
  end

  // Next-state logic; the bus messages take priority over software
  rl_state_t state;
  rl_state_t next_state;
  logic rtl;
  logic llo_ok;
  assign rtl = (state == ST_REMOTE) && enter_press;
  assign llo_ok = msg.llo && !NO_LOCKOUT_CAP;
  always_comb begin
    next_state = state;
    case (state)
      ST_LOCAL: begin
        if (msg.rem && llo_ok) begin
          next_state = ST_LOCAL_LOCK;
        end else if (msg.rem && msg.mla && !rtl) begin
          next_state = ST_REMOTE;
        end else if (sw_lock_wr && sw_lock_val && !NO_LOCKOUT_CAP) begin
          next_state = ST_LOCAL_LOCK;
        end else if (sw_rem_wr && sw_rem_val) begin
          next_state = ST_REMOTE;
        end
      end
      ST_REMOTE: begin
        if ((msg.gtl && msg.mla) || !msg.rem || (rtl && !llo_ok)) begin
          next_state = ST_LOCAL;
        end else if (llo_ok) begin
          next_state = ST_REMOTE_LOCK;
        end else if (sw_rem_wr && !sw_rem_val) begin
          next_state = ST_LOCAL;
        end else if (sw_lock_wr && sw_lock_val && !NO_LOCKOUT_CAP) begin
          next_state = ST_REMOTE_LOCK;
        end
      end
      ST_LOCAL_LOCK: begin
        // Front-panel keys never take part here
        if (!msg.rem) begin
          next_state = ST_LOCAL;
        end else if (msg.mla) begin
          next_state = ST_REMOTE_LOCK;
        end else if (sw_lock_wr && !sw_lock_val) begin
          next_state = ST_LOCAL;
        end else if (sw_rem_wr && sw_rem_val) begin
          next_state = ST_REMOTE_LOCK;
        end
      end
      ST_REMOTE_LOCK: begin
        if (!msg.rem) begin
          next_state = ST_LOCAL;
        end else if (msg.gtl) begin
          next_state = ST_LOCAL_LOCK;
        end else if (sw_lock_wr && !sw_lock_val) begin
          next_state = ST_LOCAL;
        end else if (sw_rem_wr && !sw_rem_val) begin
          next_state = ST_LOCAL_LOCK;
        end
      end
      default: begin
        next_state = ST_LOCAL;
      end
    endcase
    // Without the lockout capability a lockout state is never entered
    if (NO_LOCKOUT_CAP && (next_state == ST_LOCAL_LOCK ||
        next_state == ST_REMOTE_LOCK)) begin
      next_state = ST_LOCAL;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_LOCAL;
    end else begin
      state <= next_state;
    end
  end

  // Key gating by state, registered for clean outputs
  logic [KEY_W-1:0] remote_pass;
  logic [KEY_W-1:0] lock_pass;
  always_comb begin
    remote_pass = '0;
    lock_pass = '0;
    remote_pass[ENTER_BIT] = 1'b1;
    remote_pass[POWER_BIT] = 1'b1;
    lock_pass[POWER_BIT] = 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keys_o <= '0;
    end else begin
      case (state)
        ST_LOCAL: keys_o <= keys;
        ST_REMOTE: keys_o <= keys & remote_pass;
        ST_REMOTE_LOCK: keys_o <= keys & lock_pass;
        default: keys_o <= keys & lock_pass;
      endcase
    end
  end

  // Events: user request in lockout, and any state change
  logic urq_ev;
  logic chg_ev;
  assign urq_ev = enter_press &&
                  (state == ST_LOCAL_LOCK || state == ST_REMOTE_LOCK);
  assign chg_ev = next_state != state;

  // Display copy of state and user request pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_o <= `RL_ST_LOCS;
      urq_o <= 1'b0;
    end else begin
      state_o <= next_state;
      urq_o <= urq_ev;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic [7:0] ev_vec;
  logic [7:0] clr_vec;
  always_comb begin
    ev_vec = '0;
    ev_vec[`RL_EV_URQ] = urq_ev;
    ev_vec[`RL_EV_CHANGE] = chg_ev;
  end
  assign clr_vec = (wr_i && addr_i == `RL_ADDR_IRQ_STAT) ? wdata_i : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 8'h00;
    end else begin
      irq_stat <= (irq_stat & ~clr_vec) | ev_vec;
    end
  end

  // Mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= `RL_MASK_RESET;
    end else if (wr_i && addr_i == `RL_ADDR_IRQ_MASK) begin
      irq_mask <= wdata_i & 8'h03;
    end
  end

  // Level interrupt; registered from the next status value, so it changes with the status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat & ~clr_vec) | ev_vec) & irq_mask);
    end
  end

  // Read port, data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `RL_ADDR_CTRL: rdata_o <= {6'h00, ctrl[1:0]};
        `RL_ADDR_STATE: rdata_o <= {4'h0, state};
        `RL_ADDR_IRQ_STAT: rdata_o <= irq_stat;
        `RL_ADDR_IRQ_MASK: rdata_o <= irq_mask;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Assertions
  property p_reset_local;
    @(posedge clk_i) rst_i |=> state == ST_LOCAL;
  endproperty
  a_reset_local: assert property (p_reset_local)
    else $error("state not local after reset");

  property p_lock_keys;
    @(posedge clk_i) disable iff (rst_i)
      state == ST_REMOTE_LOCK |=> keys_o[ENTER_BIT] == 1'b0;
  endproperty
  a_lock_keys: assert property (p_lock_keys)
    else $error("enter passed in remote lockout");

  property p_local_keys;
    @(posedge clk_i) disable iff (rst_i)
      state == ST_LOCAL |=> keys_o == $past(keys);
  endproperty
  a_local_keys: assert property (p_local_keys)
    else $error("keys not passed in local");

  property p_urq;
    @(posedge clk_i) disable iff (rst_i)
      (enter_press && state == ST_LOCAL_LOCK) |=> urq_o && irq_stat[0];
  endproperty
  a_urq: assert property (p_urq)
    else $error("no user request in lockout");

  property p_no_lock_cap;
    @(posedge clk_i) disable iff (rst_i)
      NO_LOCKOUT_CAP |-> !(state == ST_LOCAL_LOCK ||
                           state == ST_REMOTE_LOCK);
  endproperty
  a_no_lock_cap: assert property (p_no_lock_cap)
    else $error("lockout reached without capability");

  property p_clear_lock;
    @(posedge clk_i) disable iff (rst_i)
      ((state == ST_LOCAL_LOCK || state == ST_REMOTE_LOCK) && !msg.rem)
      |=> state == ST_LOCAL;
  endproperty
  a_clear_lock: assert property (p_clear_lock)
    else $error("lockout not cleared by rem low");

  property p_lock_exit;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_LOCAL_LOCK && msg.rem && !sw_lock_wr)
      |=> state != ST_LOCAL;
  endproperty
  a_lock_exit: assert property (p_lock_exit)
    else $error("lockout left without command");

  property p_rem_listen;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_LOCAL && msg.rem && msg.mla && !msg.llo && !rtl)
      |=> state == ST_REMOTE;
  endproperty
  a_rem_listen: assert property (p_rem_listen)
    else $error("no move to remote");

  property p_gtl_lock;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_REMOTE_LOCK && msg.rem && msg.gtl)
      |=> state == ST_LOCAL_LOCK;
  endproperty
  a_gtl_lock: assert property (p_gtl_lock)
    else $error("gtl not honoured in remote lockout");

  property p_state_out;
    @(posedge clk_i) disable iff (rst_i) state_o == state;
  endproperty
  a_state_out: assert property (p_state_out)
    else $error("state output differs from state");

  // Only enter and power may reach the outputs while remote
  property p_remote_keys;
    @(posedge clk_i) disable iff (rst_i)
      state == ST_REMOTE |=> (keys_o & ~remote_pass) == '0;
  endproperty
  a_remote_keys: assert property (p_remote_keys)
    else $error("blocked key passed in remote");

  property p_urq_rlock;
    @(posedge clk_i) disable iff (rst_i)
      (enter_press && state == ST_REMOTE_LOCK) |=> urq_o;
  endproperty
  a_urq_rlock: assert property (p_urq_rlock)
    else $error("no user request in remote lockout");

  property p_llo_lock;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_REMOTE && msg.rem && !msg.gtl && !rtl && llo_ok)
      |=> state == ST_REMOTE_LOCK;
  endproperty
  a_llo_lock: assert property (p_llo_lock)
    else $error("llo not honoured in remote");

  property p_mla_lock;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_LOCAL_LOCK && msg.rem && msg.mla)
      |=> state == ST_REMOTE_LOCK;
  endproperty
  a_mla_lock: assert property (p_mla_lock)
    else $error("listen not honoured in local lockout");
endmodule : remote_local_state_machine

// >>> dv/ctl_model.sv
// Behavioural bus controller that drives the interface message lines
`timescale 1ns/1ps
module ctl_model
  import rl_pkg::*;
(
  input wire logic clk_i,
  output bus_msg_t msg_o
);
  // All lines idle false until the controller speaks
  initial msg_o = '0;

  // Lines move just after an edge and then hold as levels
  // Dropping rem is the only way this controller clears lockout
  task automatic put(input bus_msg_t m);
    @(posedge clk_i);
    msg_o <= m;
  endtask : put
endmodule : ctl_model

// >>> dv/remote_local_state_machine_bench.sv
// Self-checking bench for the remote/local state machine
`timescale 1ns/1ps
`include "rl_params.svh"
module remote_local_state_machine_bench;
  import rl_pkg::*;
  logic clk_i, rst_i, wr_i, rd_i, urq_o, irq_o, urq2, irq2;
  logic [3:0] addr_i, state_o, state2;
  logic [7:0] wdata_i, rdata_o, rdata2;
  logic [15:0] keys_i, keys_o, keys2;
  bus_msg_t msg_i;
  int miscompares = 0;
  int n_compared = 0;
  int urqs = 0;
  int urqs2 = 0;
  int u0;
  localparam logic [15:0] ENT = 16'h0001;
  localparam logic [15:0] PWR = 16'h0002;
  localparam logic [15:0] OTH = 16'hFFFC;

  remote_local_state_machine dut (.clk_i(clk_i), .rst_i(rst_i),
    .msg_i(msg_i), .keys_i(keys_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .keys_o(keys_o),
    .state_o(state_o), .urq_o(urq_o), .irq_o(irq_o));
  // Same stimulus into a part built without the lockout capability
  remote_local_state_machine #(.NO_LOCKOUT_CAP(1'b1)) dut2 (.clk_i(clk_i),
    .rst_i(rst_i), .msg_i(msg_i), .keys_i(keys_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata2),
    .keys_o(keys2), .state_o(state2), .urq_o(urq2), .irq_o(irq2));
  ctl_model ctl (.clk_i(clk_i), .msg_o(msg_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // The request is a single-cycle pulse, so count it as it flies by
  always @(posedge clk_i) begin
    if (urq_o === 1'b1) urqs++;
    if (urq2 === 1'b1) urqs2++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bounded poll; a message takes three edges to reach the state
  task automatic see(input logic [3:0] exp);
    for (int i = 0; i < 8 && state_o !== exp; i++) @(posedge clk_i) #1;
    chk(16'(state_o), 16'(exp));
    chk(16'(state2 & 4'hC), 16'h0000);
  endtask : see
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(16'(rdata_o), 16'(exp));
    // The reduced part sees the same register traffic
    chk(16'(rdata2), 16'(exp));
  endtask : rdc
  // Keys cross two flops and a register before keys_o follows
  task automatic key(input logic [15:0] k, input logic [15:0] exp);
    @(posedge clk_i);
    keys_i <= k;
    repeat (4) @(posedge clk_i);
    #1 chk(keys_o, exp);
  endtask : key

  task automatic t_reset();
    see(`RL_ST_LOCS);
    chk(keys_o, 16'h0000);
    rdc(`RL_ADDR_CTRL, `RL_CTRL_RESET);
    rdc(`RL_ADDR_IRQ_MASK, `RL_MASK_RESET);
    rdc(`RL_ADDR_STATE, 8'h01);
    rdc(4'h3, 8'h00);
    key(OTH | PWR | ENT, OTH | PWR | ENT);
    chk(keys2, OTH | PWR | ENT);
    key(16'h0000, 16'h0000);
  endtask : t_reset
  task automatic t_remote();
    ctl.put(4'hC);
    see(`RL_ST_REMS);
    key(OTH | PWR, PWR);
    key(16'h0000, 16'h0000);
    // Go to local lasts one cycle so listen does not pull it back
    ctl.put(4'hE);
    ctl.put(4'h8);
    see(`RL_ST_LOCS);
    ctl.put(4'hC);
    see(`RL_ST_REMS);
    ctl.put(4'h0);
    see(`RL_ST_LOCS);
    ctl.put(4'hC);
    see(`RL_ST_REMS);
    ctl.put(4'h8);
    key(ENT, ENT);
    see(`RL_ST_LOCS);
    key(16'h0000, 16'h0000);
  endtask : t_remote
  task automatic t_lock();
    ctl.put(4'h9);
    see(`RL_ST_LWLS);
    ctl.put(4'hD);
    see(`RL_ST_RWLS);
    u0 = urqs;
    key(OTH | PWR | ENT, PWR);
    chk(16'(urqs - u0), 16'h0001);
    see(`RL_ST_RWLS);
    key(16'h0000, 16'h0000);
    ctl.put(4'hB);
    see(`RL_ST_LWLS);
    key(ENT, 16'h0000); // Local lockout keeps only power
    chk(16'(urqs - u0), 16'h0002);
    see(`RL_ST_LWLS);
    key(16'h0000, 16'h0000);
    ctl.put(4'h0);
    see(`RL_ST_LOCS);
    ctl.put(4'hC);
    see(`RL_ST_REMS);
    ctl.put(4'hD);
    see(`RL_ST_RWLS);
    ctl.put(4'h0);
    see(`RL_ST_LOCS);
    chk(16'(urqs2), 16'h0000);
  endtask : t_lock
  // Rem stays high so the bus does not pull the part back to local
  task automatic t_soft();
    ctl.put(4'h8);
    wr(`RL_ADDR_CTRL, 8'h05);
    see(`RL_ST_REMS);
    wr(`RL_ADDR_CTRL, 8'h0A);
    see(`RL_ST_RWLS);
    rdc(`RL_ADDR_CTRL, 8'h03);
    wr(`RL_ADDR_STATE, 8'h01);
    wr(`RL_ADDR_CTRL, 8'h04);
    see(`RL_ST_LWLS);
    wr(`RL_ADDR_CTRL, 8'h08);
    see(`RL_ST_LOCS);
    ctl.put(4'h0);
  endtask : t_soft
  // A set mask bit lets its status bit reach the interrupt line
  task automatic t_irq();
    wr(`RL_ADDR_IRQ_STAT, 8'hFF);
    rdc(`RL_ADDR_IRQ_STAT, 8'h00);
    ctl.put(4'hC);
    see(`RL_ST_REMS);
    rdc(`RL_ADDR_IRQ_STAT, 8'h02);
    wr(`RL_ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_i);
    #1 chk(16'(irq_o), 16'h0000);
    // Unused mask bits are not stored
    wr(`RL_ADDR_IRQ_MASK, 8'hF3);
    rdc(`RL_ADDR_IRQ_MASK, 8'h03);
    chk(16'(irq_o), 16'h0001);
    chk(16'(irq2), 16'h0001);
    wr(`RL_ADDR_IRQ_STAT, 8'h02);
    rdc(`RL_ADDR_IRQ_STAT, 8'h00);
    chk(16'(irq_o), 16'h0000);
  endtask : t_irq
  // Controller lets go during reset, so nothing relocks after release
  task automatic t_power();
    ctl.put(4'hD);
    see(`RL_ST_RWLS);
    wr(`RL_ADDR_CTRL, 8'h05);
    rdc(`RL_ADDR_CTRL, 8'h01);
    @(posedge clk_i);
    rst_i <= 1'b1;
    ctl.put(4'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(16'(state_o), 16'h0001);
    rdc(`RL_ADDR_CTRL, `RL_CTRL_RESET);
    rdc(`RL_ADDR_IRQ_MASK, `RL_MASK_RESET);
    see(`RL_ST_LOCS);
  endtask : t_power

  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // The full sequence runs under two hundred cycles; this is ample margin
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    keys_i = 16'h0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_remote();
    t_lock();
    t_soft();
    t_irq();
    t_power();
    tally_and_finish();
  end
endmodule : remote_local_state_machine_bench
